/* File: src/spi_pkg.sv */
// Constants and carrier types shared by the dual serial port block
package spi_pkg;
    // Register byte offsets; port two sits one stride above port one
    localparam logic [7:0] OFF_BUF = 8'h00;
    localparam logic [7:0] OFF_CTRL = 8'h04;
    localparam logic [7:0] OFF_STAT = 8'h08;
    localparam logic [7:0] PORT_STRIDE = 8'h0C;
    localparam logic [7:0] OFF_INT_STAT = 8'h18;
    localparam logic [7:0] OFF_INT_CLR = 8'h1C;
    localparam logic [7:0] OFF_INT_EN = 8'h20;
    localparam logic [7:0] OFF_TMR_PER = 8'h24;
    localparam logic [7:0] OFF_PIN_DIR = 8'h28;

    // Status register field positions
    localparam int STAT_SMP_BIT = 7;
    localparam int STAT_CKE_BIT = 6;
    localparam int STAT_BF_BIT = 0;

    // Mode field encodings
    localparam logic [3:0] MODE_MASTER_DIV4 = 4'h0;
    localparam logic [3:0] MODE_MASTER_DIV16 = 4'h1;
    localparam logic [3:0] MODE_MASTER_DIV64 = 4'h2;
    localparam logic [3:0] MODE_MASTER_TIMER = 4'h3;
    localparam logic [3:0] MODE_SLAVE_SEL = 4'h4;
    localparam logic [3:0] MODE_SLAVE_NOSEL = 4'h5;

    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] BUF_RST = 8'h00;
    localparam logic [7:0] TMR_PER_RST = 8'h00;
    localparam logic [1:0] INT_EN_RST = 2'h0;
    localparam logic [1:0] PIN_DIR_RST = 2'h0;

    // Bit-rate divisors of the device clock and their half-bit counts
    localparam int OSC_DIV_FAST = 4;
    localparam int OSC_DIV_MID = 16;
    localparam int OSC_DIV_SLOW = 64;
    localparam logic [4:0] HALF_LAST_FAST = 5'(OSC_DIV_FAST / 2 - 1);
    localparam logic [4:0] HALF_LAST_MID = 5'(OSC_DIV_MID / 2 - 1);
    localparam logic [4:0] HALF_LAST_SLOW = 5'(OSC_DIV_SLOW / 2 - 1);
    // Byte framing counts
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [4:0] HALF_PER_BYTE_LAST = 5'h0F;

    // Control register layout
    typedef struct packed {
        logic wcol;
        logic ovf;
        logic en;
        logic cpol;
        logic [3:0] mode;
    } ctrl_type;

    // Configuration handed to a shift engine
    typedef struct packed {
        logic master;
        logic cpol;
        logic cke;
        logic sample_phase;
    } cfg_type;

    // Pin inputs of one port
    typedef struct packed {
        logic sck;
        logic ss_n;
        logic sdi;
    } pins_type;
endpackage

/* File: src/sync_two_ff.sv */
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sync_two_ff #(
    parameter int WIDTH = 1
) (
    input logic clk_i,
    input logic rst_i,
    input logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_q; // Only the second stage reads this
    logic [WIDTH-1:0] sync_q;

    // Two stages against metastability
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;
endmodule

/* File: src/spi_shift_engine.sv */
// Shift engine of one serial port: clock edges, shift registers, bit counter
`timescale 1ns/1ps
module spi_shift_engine (
    input logic clk_i,
    input logic rst_i,
    input logic clear_i,
    input spi_pkg::cfg_type cfg_i,
    input logic tick_i,
    input logic sck_pin_i,
    input logic sdi_i,
    input logic load_i,
    input logic [7:0] load_data_i,
    output logic busy_o,
    output logic done_o,
    output logic [7:0] rx_byte_o,
    output logic sdo_o,
    output logic sck_o
);
    logic sck_q; // Master clock level
    logic sck_prev_q; // Last sampled slave clock
    logic sdo_q; // Bit on the data output
    logic run_q; // Master transfer running
    logic [4:0] half_q; // Master half periods done
    logic [7:0] tx_q; // Outgoing bits
    logic [7:0] rx_q; // Incoming bits
    logic [2:0] cnt_q; // Bits sampled in this byte
    logic m_edge, s_edge, lead, trail, out_edge, samp;

    // Edge classification; leading edge leaves the idle level
    always_comb begin
        m_edge = cfg_i.master && run_q && tick_i && !clear_i;
        // Slave shifts only on edges of the external clock
        s_edge = !cfg_i.master && !clear_i && (sck_pin_i != sck_prev_q);
        lead = m_edge ? (sck_q == cfg_i.cpol) : (s_edge && (sck_pin_i != cfg_i.cpol));
        trail = m_edge ? (sck_q != cfg_i.cpol) : (s_edge && (sck_pin_i == cfg_i.cpol));
        // Edge bit set: sample leading, drive trailing
        out_edge = cfg_i.cke ? trail : lead;
        // Late sampling moves the capture to the drive edge, master only
        samp = (cfg_i.master && cfg_i.sample_phase) ? out_edge : (cfg_i.cke ? lead : trail);
    end

    // Slave clock history for edge finding
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sck_prev_q <= 1'b0;
        end else begin
            sck_prev_q <= sck_pin_i;
        end
    end

    // Master clock generation, sixteen half periods per byte
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            run_q <= 1'b0;
            half_q <= 5'h00;
            sck_q <= 1'b0;
        end else if (clear_i || !cfg_i.master) begin
            run_q <= 1'b0;
            half_q <= 5'h00;
            sck_q <= cfg_i.cpol;
        end else if (load_i && !run_q) begin
            run_q <= 1'b1;
            half_q <= 5'h00;
        end else if (m_edge) begin
            sck_q <= ~sck_q;
            half_q <= 5'(half_q + 5'h01);
            if (half_q == spi_pkg::HALF_PER_BYTE_LAST) begin
                run_q <= 1'b0;
            end
        end else if (!run_q) begin
            sck_q <= cfg_i.cpol;
        end
    end

    // Data shifting, most significant bit first
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_q <= 8'h00;
            rx_q <= 8'h00;
            sdo_q <= 1'b0;
            cnt_q <= 3'h0;
        end else begin
            // A load is taken even while the select line holds the port in reset
            if (load_i) begin
                // With the edge bit set the first bit must stand before any edge
                if (cfg_i.cke) begin
                    sdo_q <= load_data_i[7];
                    tx_q <= {load_data_i[6:0], 1'b0};
                end else begin
                    tx_q <= load_data_i;
                end
            end else if (out_edge) begin
                sdo_q <= tx_q[7];
                tx_q <= {tx_q[6:0], 1'b0};
            end
            // Port reset forces the bit counter to zero
            if (clear_i) begin
                cnt_q <= 3'h0;
            end else if (samp) begin
                rx_q <= {rx_q[6:0], sdi_i};
                cnt_q <= (cnt_q == spi_pkg::BIT_LAST) ? 3'h0 : 3'(cnt_q + 3'h1);
            end
        end
    end

    assign busy_o = run_q || (cnt_q != 3'h0);
    assign done_o = samp && (cnt_q == spi_pkg::BIT_LAST);
    assign rx_byte_o = {rx_q[6:0], sdi_i};
    assign sdo_o = sdo_q;
    assign sck_o = sck_q;
endmodule

/* File: src/spi_dual_port.sv */
// Two independent serial ports with register bank, shared timer and interrupt
`timescale 1ns/1ps

module spi_dual_port (
    input logic clk_i,
    input logic rst_i,
    input logic [7:0] addr_i,
    input logic [7:0] wdata_i,
    input logic wr_i,
    input logic rd_i,
    output logic [7:0] rdata_o,
    input logic sleep_i,
    input logic idle_i,
    output logic irq_o,
    output logic wake_o,
    input logic [1:0] serial_clock_pin_i,
    output logic [1:0] serial_clock_pin_o,
    output logic [1:0] serial_clock_pin_oe_o,
    input logic [1:0] slave_select_n_i,
    input logic [1:0] serial_data_in_i,
    output logic [1:0] serial_data_out_o,
    output logic [1:0] serial_data_out_oe_o
);
    localparam int PORTS = 2;

    // Register state
    spi_pkg::ctrl_type ctrl_q [PORTS]; // Control one per port
    logic [PORTS-1:0] smp_q; // Sample phase bits
    logic [PORTS-1:0] cke_q; // Clock edge bits
    logic [PORTS-1:0] bf_q; // Buffer full flags
    logic [7:0] buf_q [PORTS]; // Received bytes
    logic [PORTS-1:0] sdo_in_q; // Data output pin set as input
    logic [PORTS-1:0] int_stat_q; // Sticky completion events
    logic [PORTS-1:0] int_en_q; // Interrupt enables
    logic [7:0] tmr_per_q; // Shared timer period
    logic [7:0] tmr_cnt_q; // Shared timer count
    logic tmr_tick; // Shared timer overflow
    logic [7:0] rdata_q;
    logic [7:0] rd_val;
    logic irq_q;
    logic wake_q;
    logic [PORTS-1:0] sdo_oe_q;
    logic [PORTS-1:0] sck_oe_q;

    // Pins and engine results
    spi_pkg::pins_type [PORTS-1:0] pins_raw;
    spi_pkg::pins_type [PORTS-1:0] pins_sync;
    logic [PORTS-1:0] eng_busy;
    logic [PORTS-1:0] eng_done;
    logic [PORTS-1:0] eng_sdo;
    logic [PORTS-1:0] eng_sck;
    logic [7:0] eng_rx [PORTS];
    logic [PORTS-1:0] int_clr;

    // Byte address of a per-port register
    function automatic logic [7:0] port_addr(input int p, input logic [7:0] off);
        port_addr = 8'(off + 8'(p) * spi_pkg::PORT_STRIDE);
    endfunction

    // Master modes are the four lowest codes
    function automatic logic is_master(input logic [3:0] mode);
        is_master = (mode <= spi_pkg::MODE_MASTER_TIMER);
    endfunction

    // Last half-bit count for the divider modes
    function automatic logic [4:0] half_last(input logic [3:0] mode);
        case (mode)
            spi_pkg::MODE_MASTER_DIV4: half_last = spi_pkg::HALF_LAST_FAST;
            spi_pkg::MODE_MASTER_DIV16: half_last = spi_pkg::HALF_LAST_MID;
            default: half_last = spi_pkg::HALF_LAST_SLOW;
        endcase
    endfunction

    // All pin inputs pass two flops; the slave clock is sampled as data
    sync_two_ff #(
        .WIDTH($bits(pins_raw))
    ) u_pin_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(pins_raw),
        .q_o(pins_sync)
    );

    // Shared general timer; one period gives one half bit
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tmr_cnt_q <= 8'h00;
        end else if (sleep_i) begin
            tmr_cnt_q <= tmr_cnt_q; // Clocks halted in sleep
        end else if (tmr_cnt_q >= tmr_per_q) begin
            tmr_cnt_q <= 8'h00;
        end else begin
            tmr_cnt_q <= 8'(tmr_cnt_q + 8'h01);
        end
    end

    // Both ports in timer mode see the same tick, so both rates follow it
    assign tmr_tick = !sleep_i && (tmr_cnt_q >= tmr_per_q);

    // Each port is a full copy with its own mode field and divider
    for (genvar g = 0; g < PORTS; g++) begin : gen_port
        logic master; // Port runs as master
        logic sel_ctl; // Slave with select control
        logic valid; // Mode is an SPI mode
        logic ss_high; // Synchronised select is high
        logic clear; // Port logic held in reset
        logic wr_buf;
        logic rd_buf;
        logic tick; // Master half-bit tick
        logic [4:0] div_q; // Device clock divider
        spi_pkg::cfg_type cfg;

        assign pins_raw[g].sck = serial_clock_pin_i[g];
        assign pins_raw[g].ss_n = slave_select_n_i[g];
        assign pins_raw[g].sdi = serial_data_in_i[g];

        // Mode decode and port reset
        always_comb begin
            master = is_master(ctrl_q[g].mode);
            sel_ctl = (ctrl_q[g].mode == spi_pkg::MODE_SLAVE_SEL);
            valid = master || sel_ctl || (ctrl_q[g].mode == spi_pkg::MODE_SLAVE_NOSEL);
            ss_high = sel_ctl && pins_sync[g].ss_n;
            // Select high or enable low resets the shift logic
            clear = !ctrl_q[g].en || !valid || ss_high;
            wr_buf = wr_i && (addr_i == port_addr(g, spi_pkg::OFF_BUF));
            rd_buf = rd_i && (addr_i == port_addr(g, spi_pkg::OFF_BUF));
            cfg.master = master;
            cfg.cpol = ctrl_q[g].cpol;
            cfg.cke = cke_q[g];
            cfg.sample_phase = smp_q[g];
            // Sleep stops every master tick, so a transfer freezes mid-byte
            if (sleep_i) begin
                tick = 1'b0;
            end else if (ctrl_q[g].mode == spi_pkg::MODE_MASTER_TIMER) begin
                tick = tmr_tick;
            end else begin
                tick = (div_q == half_last(ctrl_q[g].mode));
            end
        end

        // Divider restarts when idle and holds its count in sleep
        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                div_q <= 5'h00;
            end else if (clear || !master || !eng_busy[g]) begin
                div_q <= 5'h00;
            end else if (sleep_i) begin
                div_q <= div_q;
            end else if (div_q == half_last(ctrl_q[g].mode)) begin
                div_q <= 5'h00;
            end else begin
                div_q <= 5'(div_q + 5'h01);
            end
        end

        spi_shift_engine u_engine (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .clear_i(clear),
            .cfg_i(cfg),
            .tick_i(tick),
            .sck_pin_i(pins_sync[g].sck),
            .sdi_i(pins_sync[g].sdi),
            .load_i(wr_buf && !eng_busy[g] && ctrl_q[g].en && valid),
            .load_data_i(wdata_i),
            .busy_o(eng_busy[g]),
            .done_o(eng_done[g]),
            .rx_byte_o(eng_rx[g]),
            .sdo_o(eng_sdo[g]),
            .sck_o(eng_sck[g])
        );

        // Control register; hardware sets beat a software write
        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                ctrl_q[g] <= spi_pkg::ctrl_type'(spi_pkg::CTRL_RST);
            end else begin
                if (wr_i && (addr_i == port_addr(g, spi_pkg::OFF_CTRL))) begin
                    ctrl_q[g] <= spi_pkg::ctrl_type'(wdata_i);
                end
                // Buffer write during a byte is dropped and flagged
                if (wr_buf && eng_busy[g] && !clear) begin
                    ctrl_q[g].wcol <= 1'b1;
                end
                // Master never overflows: each byte is started by software
                if (eng_done[g] && bf_q[g] && !master) begin
                    ctrl_q[g].ovf <= 1'b1;
                end
            end
        end

        // Status bits and receive buffer
        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                smp_q[g] <= 1'b0;
                cke_q[g] <= 1'b0;
                bf_q[g] <= 1'b0;
                buf_q[g] <= spi_pkg::BUF_RST;
            end else begin
                if (wr_i && (addr_i == port_addr(g, spi_pkg::OFF_STAT))) begin
                    smp_q[g] <= wdata_i[spi_pkg::STAT_SMP_BIT];
                    cke_q[g] <= wdata_i[spi_pkg::STAT_CKE_BIT];
                end
                // Reading the buffer empties it
                if (rd_buf) begin
                    bf_q[g] <= 1'b0;
                end
                // Slave keeps the unread byte on overflow
                if (eng_done[g] && (!bf_q[g] || master)) begin
                    buf_q[g] <= eng_rx[g];
                    bf_q[g] <= 1'b1;
                end
            end
        end

        // Pin drivers, registered so the outputs come from flops
        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                sdo_oe_q[g] <= 1'b0;
                sck_oe_q[g] <= 1'b0;
            end else begin
                // Slave with select control drives only while selected
                sdo_oe_q[g] <= ctrl_q[g].en && valid && !sdo_in_q[g] && !ss_high;
                sck_oe_q[g] <= ctrl_q[g].en && master;
            end
        end
    end

    // Global registers written by software
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            int_en_q <= spi_pkg::INT_EN_RST;
            tmr_per_q <= spi_pkg::TMR_PER_RST;
            sdo_in_q <= spi_pkg::PIN_DIR_RST;
        end else if (wr_i) begin
            if (addr_i == spi_pkg::OFF_INT_EN) begin
                int_en_q <= wdata_i[PORTS-1:0];
            end
            if (addr_i == spi_pkg::OFF_TMR_PER) begin
                tmr_per_q <= wdata_i;
            end
            if (addr_i == spi_pkg::OFF_PIN_DIR) begin
                sdo_in_q <= wdata_i[PORTS-1:0];
            end
        end
    end

    // Write-one-to-clear mask for the sticky events
    assign int_clr = (wr_i && (addr_i == spi_pkg::OFF_INT_CLR)) ? wdata_i[PORTS-1:0] : '0;

    // Sticky completion flags; a new event wins over a clear
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            int_stat_q <= '0;
        end else begin
            int_stat_q <= (int_stat_q & ~int_clr) | eng_done;
        end
    end

    // Interrupt and wake request follow the enabled flags
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            irq_q <= |(int_stat_q & int_en_q);
            // Disabled events never wake the device
            wake_q <= (sleep_i || idle_i) && |(int_stat_q & int_en_q);
        end
    end

    // Read multiplexer; unmapped and write-only addresses read zero
    always_comb begin
        rd_val = 8'h00;
        for (int p = 0; p < PORTS; p++) begin
            if (addr_i == port_addr(p, spi_pkg::OFF_BUF)) begin
                rd_val = buf_q[p];
            end
            if (addr_i == port_addr(p, spi_pkg::OFF_CTRL)) begin
                rd_val = ctrl_q[p];
            end
            if (addr_i == port_addr(p, spi_pkg::OFF_STAT)) begin
                rd_val[spi_pkg::STAT_SMP_BIT] = smp_q[p];
                rd_val[spi_pkg::STAT_CKE_BIT] = cke_q[p];
                rd_val[spi_pkg::STAT_BF_BIT] = bf_q[p];
            end
        end
        if (addr_i == spi_pkg::OFF_INT_STAT) begin
            rd_val = {6'h00, int_stat_q};
        end
        if (addr_i == spi_pkg::OFF_INT_EN) begin
            rd_val = {6'h00, int_en_q};
        end
        if (addr_i == spi_pkg::OFF_TMR_PER) begin
            rd_val = tmr_per_q;
        end
        if (addr_i == spi_pkg::OFF_PIN_DIR) begin
            rd_val = {6'h00, sdo_in_q};
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= 8'h00;
        end else if (rd_i) begin
            rdata_q <= rd_val;
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign rdata_o = rdata_q;
    assign irq_o = irq_q;
    assign wake_o = wake_q;
    assign serial_data_out_o = eng_sdo;
    assign serial_data_out_oe_o = sdo_oe_q;
    assign serial_clock_pin_o = eng_sck;
    assign serial_clock_pin_oe_o = sck_oe_q;
endmodule

/* File: tb/spi_dual_port_monitor.sv */
// Port-level timing checker for the dual serial port
`timescale 1ns/1ps
module spi_dual_port_monitor (
    input logic clk_i,
    input logic rst_i,
    input logic [7:0] addr_i,
    input logic [7:0] wdata_i,
    input logic wr_i,
    input logic sleep_i,
    input logic idle_i,
    input logic irq_o,
    input logic wake_o,
    input logic [1:0] serial_clock_pin_o,
    input logic [1:0] serial_clock_pin_oe_o,
    input logic [1:0] slave_select_n_i,
    input logic [1:0] serial_data_out_oe_o
);
    logic [5:0] ctl_q; // Port one enable, polarity and mode, snooped from bus writes
    logic dir_q; // Port one data pin turned to input
    logic sel_mode; // Port one enabled as slave with select control
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    assign sel_mode = ctl_q[5] && ctl_q[3:0] == 4'h4;
    // Shadow of the configuration, so the pin checks know the mode
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctl_q <= 6'h00;
            dir_q <= 1'b0;
        end else if (wr_i && addr_i == spi_pkg::OFF_CTRL) begin
            ctl_q <= wdata_i[5:0];
        end else if (wr_i && addr_i == spi_pkg::OFF_PIN_DIR) begin
            dir_q <= wdata_i[0];
        end
    end
    // Data output enables and interrupt are quiet at the first edge after any reset
    reset_quiet_a: assert property ($past(rst_i) |-> serial_data_out_oe_o == 2'h0 && !irq_o)
        else $error("pins driven right after reset");
    // Select held high: output released; latency is two sync stages and one register
    sel_release_a: assert property ((sel_mode && slave_select_n_i[0]) [*4] |-> !serial_data_out_oe_o[0])
        else $error("data out driven while deselected");
    sel_drive_a: assert property ((sel_mode && !dir_q && !slave_select_n_i[0]) [*4] |-> serial_data_out_oe_o[0])
        else $error("data out not driven while selected");
    dir_input_a: assert property (dir_q [*2] |-> !serial_data_out_oe_o[0])
        else $error("data out driven while pin is input");
    sleep_freeze_a: assert property (sleep_i [*3] |-> $stable(serial_clock_pin_o))
        else $error("serial clock moved in sleep");
    wake_needs_a: assert property (wake_o |-> irq_o && ($past(sleep_i) || $past(idle_i)))
        else $error("wake without enabled event");
    wake_follows_a: assert property (irq_o && ($past(sleep_i) || $past(idle_i)) |-> wake_o)
        else $error("enabled event did not wake");
    clk_oe_mode_a: assert property ($stable(ctl_q) [*2] |-> serial_clock_pin_oe_o[0] == (ctl_q[5] && ctl_q[3:2] == 2'h0))
        else $error("clock drive does not follow mode");
endmodule
bind spi_dual_port spi_dual_port_monitor i_spi_dual_port_monitor (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i,
    .sleep_i, .idle_i, .irq_o, .wake_o, .serial_clock_pin_o, .serial_clock_pin_oe_o, .slave_select_n_i,
    .serial_data_out_oe_o);

/* File: tb/spi_ext_master.sv */
// External SPI master in mode 0,0 facing the slave port
`timescale 1ns/1ps
module spi_ext_master (
    input wire logic sdo_i,
    input wire logic sdo_oe_i,
    output logic sck_o,
    output logic ss_n_o,
    output logic mosi_o
);
    // Clock stands still at idle low between frames
    initial begin
        sck_o = 1'b0;
        ss_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    // Shift nbits MSB first at 160 ns per bit; change on falling, sample on rising
    task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
        #3 ss_n_o = 1'b0;
        #400;
        for (int i = 7; i > 7 - nbits; i--) begin
            mosi_o = tx[i];
            #80 sck_o = 1'b1;
            rx = {rx[6:0], sdo_oe_i ? sdo_i : ~sdo_i}; // Floating line never reads as the last bit
            #80 sck_o = 1'b0;
        end
        mosi_o = ~mosi_o; // Released line no longer shows the last bit
        #400 ss_n_o = 1'b1;
        #400;
    endtask
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench of the dual serial port
`timescale 1ns/1ps
module tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic sleep_i = 1'b0;
    logic idle_i = 1'b0;
    logic [7:0] rdata_o, got, rx, d;
    logic irq_o, wake_o, ext_sck, ext_ss_n, ext_mosi;
    logic [1:0] serial_clock_pin_o, serial_clock_pin_oe_o, serial_data_out_o, serial_data_out_oe_o;
    int failures = 0;
    int total_checks = 0;
    typedef struct {logic [7:0] addr; logic wr; logic [7:0] wdata; logic [7:0] exp;} row_type;
    // Reset values first, then write and read back; 0x30 is unmapped, 0x1C write-only; period 1F matches /64
    row_type rows [14] = '{'{8'h00, 0, 0, 0}, '{8'h04, 0, 0, 0}, '{8'h08, 0, 0, 0}, '{8'h10, 0, 0, 0},
        '{8'h20, 0, 0, 0}, '{8'h24, 0, 0, 0}, '{8'h28, 0, 0, 0}, '{8'h24, 1, 8'h1F, 8'h1F},
        '{8'h20, 1, 8'h03, 8'h03}, '{8'h08, 1, 8'hC1, 8'hC0}, '{8'h10, 1, 8'h15, 8'h15},
        '{8'h1C, 1, 8'h03, 8'h00}, '{8'h30, 1, 8'hFF, 8'h00}, '{8'h28, 1, 8'h00, 8'h00}};
    spi_dual_port i_spi_dual_port (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .sleep_i, .idle_i,
        .irq_o, .wake_o, .serial_clock_pin_i({1'b0, ext_sck}), .serial_clock_pin_o, .serial_clock_pin_oe_o,
        .slave_select_n_i({1'b1, ext_ss_n}), .serial_data_in_i({serial_data_out_o[1], ext_mosi}),
        .serial_data_out_o, .serial_data_out_oe_o);
    // Port one faces the external master; port two loops its output back as two-wire
    spi_ext_master i_spi_ext_master (.sdo_i(serial_data_out_o[0]), .sdo_oe_i(serial_data_out_oe_o[0]),
        .sck_o(ext_sck), .ss_n_o(ext_ss_n), .mosi_o(ext_mosi));
    // 100 MHz device clock
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    // Bus write; one idle cycle after so a strobe is never set twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // Bus read; data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 got = rdata_o;
        @(posedge clk_i);
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        total_checks++;
        if (s !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    // One slave frame from the external master, then back onto the clock edge
    task automatic sx(input logic [7:0] t, input int n);
        i_spi_ext_master.xfer(t, n, rx);
        @(posedge clk_i);
    endtask
    task automatic summarize;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Watchdog: the tests need well under 60 us
    initial begin
        #300000;
        failures++;
        summarize();
    end
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                wr(rows[i].addr, rows[i].wdata);
            end
            rd(rows[i].addr);
            chk("register", rows[i].exp, got);
        end
        $display("register rows done");
        // Port two master at /64, then timer mode at the same rate; loopback, sleep, irq enabled then masked
        wr(8'h14, 8'h40);
        for (int k = 0; k < 2; k++) begin
            d = k ? 8'h5A : 8'hA5;
            wr(8'h10, k ? 8'h23 : 8'h22);
            wr(8'h20, k ? 8'h00 : 8'h02);
            wr(8'h0C, d);
            #1 chk("first bit", {7'h00, d[7]}, {7'h00, serial_data_out_o[1]});
            @(posedge clk_i);
            sleep_i <= 1'b1;
            repeat (100) @(posedge clk_i);
            sleep_i <= 1'b0;
            idle_i <= 1'b1;
            repeat (700) @(posedge clk_i);
            #1 chk("wake", {7'h00, ~k[0]}, {7'h00, wake_o});
            @(posedge clk_i);
            rd(8'h18);
            chk("int status", 8'h02, got);
            rd(8'h0C);
            chk("master byte", d, got);
            wr(8'h1C, 8'h02);
            @(negedge clk_i);
            chk("irq cleared", 8'h00, {7'h00, irq_o});
            @(posedge clk_i);
        end
        idle_i <= 1'b0;
        $display("master transfers done");
        // Port one slave with select control, mode 0,0; a frame cut short must not misalign the next
        wr(8'h04, 8'h24);
        wr(8'h08, 8'h40);
        wr(8'h00, 8'h3C);
        sx(8'hC3, 8);
        chk("slave tx", 8'h3C, rx);
        rd(8'h00);
        chk("slave rx", 8'hC3, got);
        wr(8'h28, 8'h01);
        sx(8'hFF, 4);
        wr(8'h28, 8'h00);
        @(posedge clk_i);
        chk("released", 8'h00, {7'h00, serial_data_out_oe_o[0]});
        wr(8'h00, 8'h69);
        sx(8'h96, 8);
        chk("slave tx after cut", 8'h69, rx);
        rd(8'h00);
        chk("slave rx after cut", 8'h96, got);
        $display("slave transfers done");
        // Reset in mid-transfer disables the port
        wr(8'h0C, 8'h11);
        repeat (50) @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(8'h10);
        chk("control after reset", 8'h00, got);
        chk("clock drive after reset", 8'h00, {6'h00, serial_clock_pin_oe_o});
        $display("reset test done");
        summarize();
    end
endmodule
